// *** verilog/kgls_top.v ***
// keypad row/column gpio outputs, supply select and level translators
`include "kgls_defines.vh"

module kgls_top (
	input wire clk_sys,
	input wire nrst,
	input wire ce,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata_q,
	input wire [7:0] row_in,
	output reg [7:0] row_out_q,
	output reg [7:0] row_oe_q,
	input wire [7:0] col_in,
	output reg [7:0] col_out_q,
	output reg [7:0] col_oe_q,
	output reg [7:0] row_alternate_logic_supply_q,
	output reg [7:0] col_alternate_logic_supply_q
);

	// =====================================================
	// register state
	reg [7:0] row_dir_q;
	reg [7:0] col_dir_q;
	reg [7:0] row_mode_q;
	reg [7:0] col_mode_q;
	reg [7:0] row_supply_select_q;
	reg [7:0] column_supply_select_q;
	reg [7:0] row_output_values_q;
	reg [7:0] column_output_values_q;
	reg [7:0] translator_pair_enable_q;
	reg [7:0] global_q;

	wire [7:0] row_sync;
	wire [7:0] col_sync;

	reg [7:0] row_out_d;
	reg [7:0] row_oe_d;
	reg [7:0] col_out_d;
	reg [7:0] col_oe_d;
	reg [7:0] rdata_d;
	reg [1:0] drv;
	integer n;

	wire gpio_reset_req;

	// =====================================================
	// pin drive: {out, oe} for a value and push-pull flag
	function [1:0] pin_drive;
		input value;
		input push_pull;
		begin
			if (push_pull) begin
				pin_drive = {value, 1'b1};
			end else begin
				pin_drive = {1'b0, ~value};
			end
		end
	endfunction

	// =====================================================
	// input synchronisers
	kgls_sync #(
		.WIDTH(`KGLS_PINS)
	) u_row_sync (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.ce(ce),
		.pin_async(row_in),
		.pin_sync_q(row_sync)
	);

	kgls_sync #(
		.WIDTH(`KGLS_PINS)
	) u_col_sync (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.ce(ce),
		.pin_async(col_in),
		.pin_sync_q(col_sync)
	);

	// =====================================================
	// register writes
	assign gpio_reset_req = reg_wr && (reg_addr == `KGLS_OFS_GLOBAL) &&
		reg_wdata[`KGLS_GLOBAL_RST_BIT];

	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			row_dir_q <= `KGLS_RST_DIR;
			col_dir_q <= `KGLS_RST_DIR;
			row_mode_q <= `KGLS_RST_ROW_MODE;
			col_mode_q <= `KGLS_RST_COL_MODE;
			row_supply_select_q <= `KGLS_RST_SUPPLY;
			column_supply_select_q <= `KGLS_RST_SUPPLY;
			row_output_values_q <= `KGLS_RST_VAL;
			column_output_values_q <= `KGLS_RST_VAL;
			translator_pair_enable_q <= `KGLS_RST_PAIR_EN;
			global_q <= `KGLS_RST_GLOBAL;
		end else if (ce) begin
			if (gpio_reset_req) begin
				// restore power-on values; reset bit never stored
				row_dir_q <= `KGLS_RST_DIR;
				col_dir_q <= `KGLS_RST_DIR;
				row_mode_q <= `KGLS_RST_ROW_MODE;
				col_mode_q <= `KGLS_RST_COL_MODE;
				row_supply_select_q <= `KGLS_RST_SUPPLY;
				column_supply_select_q <= `KGLS_RST_SUPPLY;
				row_output_values_q <= `KGLS_RST_VAL;
				column_output_values_q <= `KGLS_RST_VAL;
				translator_pair_enable_q <= `KGLS_RST_PAIR_EN;
				global_q <= `KGLS_RST_GLOBAL;
			end else if (reg_wr) begin
				case (reg_addr)
					`KGLS_OFS_ROW_DIR: row_dir_q <= reg_wdata;
					`KGLS_OFS_COL_DIR: col_dir_q <= reg_wdata;
					`KGLS_OFS_ROW_MODE: row_mode_q <= reg_wdata;
					`KGLS_OFS_COL_MODE: begin
						col_mode_q <= reg_wdata & `KGLS_COL_MODE_MASK;
					end
					`KGLS_OFS_ROW_SUPPLY: row_supply_select_q <= reg_wdata;
					`KGLS_OFS_COL_SUPPLY: column_supply_select_q <= reg_wdata;
					`KGLS_OFS_ROW_VAL: row_output_values_q <= reg_wdata;
					`KGLS_OFS_COL_VAL: column_output_values_q <= reg_wdata;
					`KGLS_OFS_PAIR_EN: translator_pair_enable_q <= reg_wdata;
					`KGLS_OFS_GLOBAL: global_q <= reg_wdata & `KGLS_GLOBAL_KEEP_MASK;
					default: begin
					end
				endcase
			end
		end
	end

	// =====================================================
	// read mux
	always @* begin
		case (reg_addr)
			`KGLS_OFS_ROW_DIR: rdata_d = row_dir_q;
			`KGLS_OFS_COL_DIR: rdata_d = col_dir_q;
			`KGLS_OFS_ROW_MODE: rdata_d = row_mode_q;
			`KGLS_OFS_COL_MODE: rdata_d = col_mode_q;
			`KGLS_OFS_ROW_SUPPLY: rdata_d = row_supply_select_q;
			`KGLS_OFS_COL_SUPPLY: rdata_d = column_supply_select_q;
			`KGLS_OFS_ROW_VAL: rdata_d = row_output_values_q;
			`KGLS_OFS_COL_VAL: rdata_d = column_output_values_q;
			`KGLS_OFS_PAIR_EN: rdata_d = translator_pair_enable_q;
			`KGLS_OFS_GLOBAL: rdata_d = global_q;
			default: rdata_d = `KGLS_READ_NONE;
		endcase
	end

	// =====================================================
	// pin drive per channel
	always @* begin
		row_out_d = `KGLS_PIN_IDLE;
		row_oe_d = `KGLS_PIN_IDLE;
		col_out_d = `KGLS_PIN_IDLE;
		col_oe_d = `KGLS_PIN_IDLE;
		drv = 2'b00;
		for (n = 0; n < `KGLS_PINS; n = n + 1) begin
			if (translator_pair_enable_q[n]) begin
				if (col_dir_q[n]) begin
					// row in, column out
					drv = pin_drive(row_sync[n], col_mode_q[n]);
					col_out_d[n] = drv[1];
					col_oe_d[n] = drv[0];
				end else begin
					// column in, row out
					drv = pin_drive(col_sync[n], row_mode_q[n]);
					row_out_d[n] = drv[1];
					row_oe_d[n] = drv[0];
				end
			end else begin
				if (row_dir_q[n]) begin
					drv = pin_drive(row_output_values_q[n], row_mode_q[n]);
					row_out_d[n] = drv[1];
					row_oe_d[n] = drv[0];
				end
				if (col_dir_q[n]) begin
					// upper columns have mode bit held at zero
					drv = pin_drive(column_output_values_q[n], col_mode_q[n]);
					col_out_d[n] = drv[1];
					col_oe_d[n] = drv[0];
				end
			end
		end
	end

	// =====================================================
	// output flops
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			reg_rdata_q <= `KGLS_READ_NONE;
			row_out_q <= `KGLS_PIN_IDLE;
			row_oe_q <= `KGLS_PIN_IDLE;
			col_out_q <= `KGLS_PIN_IDLE;
			col_oe_q <= `KGLS_PIN_IDLE;
			row_alternate_logic_supply_q <= `KGLS_RST_SUPPLY;
			col_alternate_logic_supply_q <= `KGLS_RST_SUPPLY;
		end else if (ce) begin
			if (reg_rd) begin
				reg_rdata_q <= rdata_d;
			end
			row_out_q <= row_out_d;
			row_oe_q <= row_oe_d;
			col_out_q <= col_out_d;
			col_oe_q <= col_oe_d;
			row_alternate_logic_supply_q <= row_supply_select_q;
			col_alternate_logic_supply_q <= column_supply_select_q;
		end
	end

endmodule

// *** verilog/kgls_defines.vh ***
// constants for the keypad gpio output and level-translator block
`ifndef KGLS_DEFINES_VH
`define KGLS_DEFINES_VH

// =====================================================
// register offsets
`define KGLS_OFS_ROW_DIR 8'h34
`define KGLS_OFS_COL_DIR 8'h35
`define KGLS_OFS_ROW_MODE 8'h36
`define KGLS_OFS_COL_MODE 8'h37
`define KGLS_OFS_ROW_SUPPLY 8'h38
`define KGLS_OFS_COL_SUPPLY 8'h39
`define KGLS_OFS_ROW_VAL 8'h3A
`define KGLS_OFS_COL_VAL 8'h3B
`define KGLS_OFS_PAIR_EN 8'h3C
`define KGLS_OFS_GLOBAL 8'h40

// =====================================================
// power-on values
`define KGLS_RST_DIR 8'h00
`define KGLS_RST_ROW_MODE 8'hFF
`define KGLS_RST_COL_MODE 8'h0F
`define KGLS_RST_SUPPLY 8'h00
`define KGLS_RST_VAL 8'hFF
`define KGLS_RST_PAIR_EN 8'h00
`define KGLS_RST_GLOBAL 8'h00

// =====================================================
// field layout
`define KGLS_COL_MODE_MASK 8'h0F
`define KGLS_GLOBAL_RST_BIT 3
`define KGLS_GLOBAL_KEEP_MASK 8'h37
`define KGLS_READ_NONE 8'h00
`define KGLS_PIN_IDLE 8'h00
`define KGLS_PINS 8

`endif

// *** verilog/kgls_sync.v ***
// two-stage synchroniser for a group of pin inputs
module kgls_sync #(
	parameter WIDTH = 8
) (
	input wire clk_sys,
	input wire nrst,
	input wire ce,
	input wire [WIDTH-1:0] pin_async,
	output reg [WIDTH-1:0] pin_sync_q
);

	reg [WIDTH-1:0] meta_q;

	// =====================================================
	// two flops, first read only by the second
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			meta_q <= {WIDTH{1'b0}};
			pin_sync_q <= {WIDTH{1'b0}};
		end else if (ce) begin
			meta_q <= pin_async;
			pin_sync_q <= meta_q;
		end
	end

endmodule

// *** tb/kgls_monitor.sv ***
// port checker for the keypad gpio block
// ====
// checks
module kgls_monitor (
	input wire clk_sys,
	input wire nrst,
	input wire ce,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata_q,
	input wire [7:0] row_out_q,
	input wire [7:0] row_oe_q,
	input wire [7:0] col_out_q,
	input wire [7:0] col_oe_q,
	input wire [7:0] row_alternate_logic_supply_q,
	input wire [7:0] col_alternate_logic_supply_q
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	a_row_sup_copy: assert property (ce && reg_wr && reg_addr == 8'h38 ##1 ce |=>
		row_alternate_logic_supply_q == $past(reg_wdata, 2)) else $error("row supply");
	a_col_sup_copy: assert property (ce && reg_wr && reg_addr == 8'h39 ##1 ce |=>
		col_alternate_logic_supply_q == $past(reg_wdata, 2)) else $error("col supply");
	a_row_no_float: assert property ((row_out_q & ~row_oe_q) == 8'h00) else $error("row");
	a_col_no_float: assert property ((col_out_q & ~col_oe_q) == 8'h00) else $error("col");
	a_od_no_high: assert property (col_out_q[7:4] == 4'h0) else $error("col drives high");
	a_rst_all_zero: assert property ($rose(nrst) |-> (row_oe_q | col_oe_q) == 8'h00 &&
		(row_alternate_logic_supply_q | col_alternate_logic_supply_q) == 8'h00) else $error("rst");
	a_mode_hi_zero: assert property (ce && reg_rd && reg_addr == 8'h37 |=>
		reg_rdata_q[7:4] == 4'h0) else $error("mode bits");
	a_glb_bit_zero: assert property (ce && reg_rd && reg_addr == 8'h40 |=>
		!reg_rdata_q[3]) else $error("reset bit");
	a_glb_clear: assert property (ce && reg_wr && reg_addr == 8'h40 && reg_wdata[3] ##1 ce |=>
		(row_oe_q | col_oe_q | row_alternate_logic_supply_q |
		col_alternate_logic_supply_q) == 8'h00) else $error("global");
endmodule

bind kgls_top kgls_monitor i_mon (.clk_sys, .nrst, .ce, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata_q, .row_out_q, .row_oe_q, .col_out_q, .col_oe_q,
	.row_alternate_logic_supply_q, .col_alternate_logic_supply_q);

// *** tb/kgls_pins.sv ***
// pin loads: pull-ups and outside drivers on rows and columns
module kgls_pins (
	input wire [7:0] row_out_q,
	input wire [7:0] row_oe_q,
	input wire [7:0] col_out_q,
	input wire [7:0] col_oe_q,
	input wire [7:0] xrow,
	input wire [7:0] xrow_en,
	input wire [7:0] xcol,
	input wire [7:0] xcol_en,
	output wire [7:0] row_in,
	output wire [7:0] col_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// released and undriven pins sit high
	assign row_in = (row_oe_q & row_out_q) | (~row_oe_q & (~xrow_en | xrow));
	assign col_in = (col_oe_q & col_out_q) | (~col_oe_q & (~xcol_en | xcol));
endmodule

// *** tb/kgls_top_tb.sv ***
// bench for the keypad gpio block
module kgls_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	reg clk_sys = 0, nrst = 0, ce = 1, reg_wr = 0, reg_rd = 0;
	reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
	reg [7:0] xrow = 8'h00, xrow_en = 8'h00, xcol = 8'h00, xcol_en = 8'h00;
	wire [7:0] reg_rdata_q, row_in, row_out_q, row_oe_q, col_in, col_out_q, col_oe_q;
	wire [7:0] row_alternate_logic_supply_q, col_alternate_logic_supply_q;
	int fail_count = 0;
	int total_checks = 0;
	always #2.5 clk_sys = ~clk_sys;
	kgls_top i_dut (.clk_sys, .nrst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata_q, .row_in, .row_out_q, .row_oe_q, .col_in, .col_out_q, .col_oe_q,
		.row_alternate_logic_supply_q, .col_alternate_logic_supply_q);
	kgls_pins i_pins (.row_out_q, .row_oe_q, .col_out_q, .col_oe_q, .xrow, .xrow_en,
		.xcol, .xcol_en, .row_in, .col_in);
	// ====
	// helpers
	task chk(input [7:0] got, input [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task wr(input [7:0] a, input [7:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		@(negedge clk_sys);
		reg_wr = 0;
	endtask
	task rdc(input [7:0] a, input [7:0] e);
		@(negedge clk_sys);
		reg_addr = a;
		reg_rd = 1;
		@(negedge clk_sys);
		reg_rd = 0;
		chk(reg_rdata_q, e);
	endtask
	task report_and_stop;
		if (fail_count == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ====
	// scenarios
	task t_reset;
		rdc(8'h38, 8'h00);
		rdc(8'h39, 8'h00);
		rdc(8'h3C, 8'h00);
		rdc(8'h35, 8'h00);
		rdc(8'h41, 8'h00);
	endtask
	task t_supply;
		wr(8'h38, 8'hA5);
		wr(8'h39, 8'h5A);
		cyc(1);
		chk(row_alternate_logic_supply_q, 8'hA5);
		chk(col_alternate_logic_supply_q, 8'h5A);
		rdc(8'h39, 8'h5A);
	endtask
	task t_freeze;
		ce = 0;
		wr(8'h38, 8'hFF);
		cyc(2);
		chk(row_alternate_logic_supply_q, 8'hA5);
		ce = 1;
		rdc(8'h38, 8'hA5);
	endtask
	task t_gpo;
		wr(8'h34, 8'hFF);
		wr(8'h36, 8'hF0);
		wr(8'h3A, 8'h5A);
		wr(8'h35, 8'hFF);
		wr(8'h37, 8'hFF);
		wr(8'h3B, 8'h5A);
		cyc(1);
		chk(row_oe_q, 8'hF5);
		chk(row_out_q, 8'h50);
		chk(col_oe_q, 8'hAF);
		chk(col_out_q, 8'h0A);
		chk(col_in, 8'h5A);
		rdc(8'h37, 8'h0F);
	endtask
	task t_pair;
		xrow_en = 8'h01;
		xrow = 8'h01;
		wr(8'h3C, 8'h01);
		cyc(4);
		chk(row_oe_q, 8'hF4);
		chk(col_out_q, 8'h0B);
		xrow = 8'h00;
		cyc(3);
		chk(col_out_q, 8'h0A);
		xrow_en = 8'h00;
		xcol_en = 8'h01;
		wr(8'h35, 8'hFE);
		cyc(4);
		chk(col_oe_q, 8'hAE);
		chk(row_oe_q, 8'hF5);
		xcol = 8'h01;
		cyc(3);
		chk(row_oe_q, 8'hF4);
		wr(8'h3C, 8'h00);
		cyc(1);
		chk(row_oe_q, 8'hF5);
		chk(col_oe_q, 8'hAE);
		xcol_en = 8'h00;
	endtask
	task t_glob;
		wr(8'h40, 8'h0F);
		cyc(1);
		chk(row_oe_q | col_oe_q | row_alternate_logic_supply_q, 8'h00);
		chk(col_alternate_logic_supply_q, 8'h00);
		rdc(8'h40, 8'h00);
		rdc(8'h3A, 8'hFF);
		wr(8'h40, 8'hF7);
		rdc(8'h40, 8'h37);
	endtask
	initial begin
		cyc(20);
		nrst = 1;
		t_reset;
		t_supply;
		t_freeze;
		t_gpo;
		t_pair;
		t_glob;
		report_and_stop;
	end
	initial begin
		#5000;
		fail_count++;
		report_and_stop;
	end
endmodule
